// ### logic/fcsu_host.v
// APB-driven host controller for a byte-wide flash command interface
`timescale 1ns/1ps
`default_nettype none
`include "fcsu_consts.vh"
module fcsu_host (
  input wire mclk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] dqIn,
  output wire [7:0] dqOut,
  output wire dqOe,
  output wire [19:0] flashAddr,
  output wire chipSelectN,
  output wire writeStrobeN,
  output wire outputEnableN,
  output reg powerdown_reset_n,
  input wire ready_busy_n
);
  localparam S_IDLE = 3'd0;
  localparam S_FIRST = 3'd1;
  localparam S_SECOND = 3'd2;
  localparam S_POLLCMD = 3'd3;
  localparam S_POLL = 3'd4;
  localparam S_DONE = 3'd5;

  reg [2:0] state_q;
  reg [2:0] op_q;
  reg [7:0] cmd_q;
  reg [19:0] addr_q;
  reg [7:0] wdata_q;
  reg [7:0] rdata_q;
  reg [7:0] status_q;
  reg doneFlag_q;
  reg cmdError_q;
  reg rbSync1_q;
  reg rbSync2_q;
  reg cycStart;
  reg cycWrite;
  reg [19:0] cycAddr;
  reg [7:0] cycData;
  wire cycBusy;
  wire cycDone;
  wire [7:0] cycRdata;

  wire apbWrite = psel & penable & pwrite;
  wire ctrlGo = apbWrite & (paddr == `FCSU_REG_CTRL) & (state_q == S_IDLE);
  wire [2:0] goOp = pwdata[2:0];
  // Command bytes outside the defined set, and the erase and write setup bytes, are refused here rather than sent
  wire cmdLegal = (pwdata[15:8] == `FCSU_CMD_READ_ARRAY) | (pwdata[15:8] == `FCSU_CMD_IDENT)
    | (pwdata[15:8] == `FCSU_CMD_READ_STATUS) | (pwdata[15:8] == `FCSU_CMD_CLEAR_STATUS)
    | (pwdata[15:8] == `FCSU_CMD_CONFIRM) | (pwdata[15:8] == `FCSU_CMD_SUSPEND);
  // A seen supply-low flag blocks write and erase until software clears status
  wire supplyLowSeen = status_q[`FCSU_SR_SUPPLY_LOW];
  wire goOk = (goOp == `FCSU_OP_CMD) ? cmdLegal :
    ((goOp == `FCSU_OP_READ) | (goOp == `FCSU_OP_POLL)
    | (((goOp == `FCSU_OP_PROGRAM) | (goOp == `FCSU_OP_ERASE)) & ~supplyLowSeen));
  wire opIsProgram = (op_q == `FCSU_OP_PROGRAM);
  wire opIsErase = (op_q == `FCSU_OP_ERASE);

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rbSync1_q <= 1'b1;
      rbSync2_q <= 1'b1;
    end else begin
      rbSync1_q <= ready_busy_n;
      rbSync2_q <= rbSync1_q;
    end
  end

  always @* begin
    cycStart = 1'b0;
    cycWrite = 1'b1;
    cycAddr = addr_q;
    cycData = cmd_q;
    case (state_q)
      S_FIRST: begin
        cycStart = ~cycBusy;
        cycWrite = (op_q != `FCSU_OP_READ);
        if (opIsProgram) begin
          cycData = `FCSU_CMD_WRITE_SETUP;
        end else if (opIsErase) begin
          cycData = `FCSU_CMD_ERASE_SETUP;
        end else if (op_q == `FCSU_OP_POLL) begin
          cycData = `FCSU_CMD_READ_STATUS;
        end
      end
      S_SECOND: begin
        cycStart = ~cycBusy;
        cycData = opIsProgram ? wdata_q : `FCSU_CMD_CONFIRM;
      end
      S_POLL: begin
        // Fresh cycle per read so the status latch updates
        cycStart = ~cycBusy;
        cycWrite = 1'b0;
      end
      default: begin
        cycStart = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      op_q <= `FCSU_OP_NONE;
      cmd_q <= 8'h00;
      addr_q <= 20'h00000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      status_q <= 8'h00;
      doneFlag_q <= 1'b0;
      cmdError_q <= 1'b0;
      powerdown_reset_n <= 1'b0;
    end else begin
      if (apbWrite & (paddr == `FCSU_REG_ADDR)) begin
        addr_q <= pwdata[19:0];
      end
      if (apbWrite & (paddr == `FCSU_REG_WDATA)) begin
        wdata_q <= pwdata[7:0];
      end
      if (apbWrite & (paddr == `FCSU_REG_CTRL)) begin
        // Holding powerdown low returns the device to array read and clean status
        powerdown_reset_n <= pwdata[31];
      end
      case (state_q)
        S_IDLE: begin
          if (ctrlGo & pwdata[31] & (goOp != `FCSU_OP_NONE)) begin
            if (goOk) begin
              if ((goOp == `FCSU_OP_CMD) & (pwdata[15:8] == `FCSU_CMD_CLEAR_STATUS)) begin
                status_q <= 8'h00;
              end
              op_q <= goOp;
              cmd_q <= pwdata[15:8];
              doneFlag_q <= 1'b0;
              cmdError_q <= 1'b0;
              state_q <= S_FIRST;
            end else begin
              cmdError_q <= 1'b1;
            end
          end
        end
        S_FIRST: begin
          if (cycDone) begin
            if (op_q == `FCSU_OP_READ) begin
              rdata_q <= cycRdata;
              state_q <= S_DONE;
            end else if (opIsProgram | opIsErase) begin
              state_q <= S_SECOND;
            end else if (op_q == `FCSU_OP_POLL) begin
              state_q <= S_POLL;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_SECOND: begin
          if (cycDone) begin
            state_q <= S_POLL;
          end
        end
        S_POLL: begin
          if (cycDone) begin
            status_q <= cycRdata & `FCSU_SR_USED_MASK;
            // Error bits are only trusted once the machine reports ready
            if (cycRdata[`FCSU_SR_READY] & rbSync2_q) begin
              state_q <= S_DONE;
            end
          end
        end
        S_DONE: begin
          doneFlag_q <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always @* begin
    prdata = 32'h00000000;
    case (paddr)
      `FCSU_REG_CTRL: prdata = {powerdown_reset_n, 23'h000000, cmd_q};
      `FCSU_REG_ADDR: prdata = {12'h000, addr_q};
      `FCSU_REG_WDATA: prdata = {24'h000000, wdata_q};
      `FCSU_REG_STATUS: prdata = {20'h00000, rbSync2_q, cmdError_q, doneFlag_q,
        (state_q != S_IDLE), status_q[7:3], 3'h0};
      `FCSU_REG_RDATA: prdata = {24'h000000, rdata_q};
      default: prdata = 32'h00000000;
    endcase
  end

  fcsu_bus_cycle u_cycle (
    .mclk(mclk),
    .rstn(rstn),
    .start(cycStart),
    .isWrite(cycWrite),
    .addr(cycAddr),
    .wdata(cycData),
    .dqIn(dqIn),
    .busy(cycBusy),
    .done(cycDone),
    .rdata(cycRdata),
    .flashAddr(flashAddr),
    .dqOut(dqOut),
    .dqOe(dqOe),
    .chipSelectN(chipSelectN),
    .writeStrobeN(writeStrobeN),
    .outputEnableN(outputEnableN)
  );
endmodule // fcsu_host
`default_nettype wire

// ### inc/fcsu_consts.vh
// Constants of the flash command host controller
`ifndef FCSU_CONSTS_VH
`define FCSU_CONSTS_VH
`define FCSU_CMD_READ_ARRAY 8'hFF
`define FCSU_CMD_IDENT 8'h90
`define FCSU_CMD_READ_STATUS 8'h70
`define FCSU_CMD_CLEAR_STATUS 8'h50
`define FCSU_CMD_ERASE_SETUP 8'h20
`define FCSU_CMD_CONFIRM 8'hD0
`define FCSU_CMD_SUSPEND 8'hB0
`define FCSU_CMD_WRITE_SETUP 8'h40
`define FCSU_CMD_WRITE_SETUP_ALT 8'h10
`define FCSU_ADDR_MFR 20'h00000
`define FCSU_ADDR_DEV 20'h00001
`define FCSU_SR_READY 7
`define FCSU_SR_PAUSED 6
`define FCSU_SR_ERASE_ERR 5
`define FCSU_SR_WRITE_ERR 4
`define FCSU_SR_SUPPLY_LOW 3
`define FCSU_SR_USED_MASK 8'hF8
`define FCSU_REG_CTRL 12'h000
`define FCSU_REG_ADDR 12'h004
`define FCSU_REG_WDATA 12'h008
`define FCSU_REG_STATUS 12'h00C
`define FCSU_REG_RDATA 12'h010
`define FCSU_OP_NONE 3'h0
`define FCSU_OP_CMD 3'h1
`define FCSU_OP_READ 3'h2
`define FCSU_OP_PROGRAM 3'h3
`define FCSU_OP_ERASE 3'h4
`define FCSU_OP_POLL 3'h5
`define FCSU_STROBE_CYCLES 4'h4
`define FCSU_GAP_CYCLES 4'h2
`endif

// ### logic/fcsu_bus_cycle.v
// One strobe cycle on the flash pins: a command write or a read
`timescale 1ns/1ps
`default_nettype none
`include "fcsu_consts.vh"
module fcsu_bus_cycle (
  input wire mclk,
  input wire rstn,
  input wire start,
  input wire isWrite,
  input wire [19:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] dqIn,
  output wire busy,
  output reg done,
  output reg [7:0] rdata,
  output reg [19:0] flashAddr,
  output reg [7:0] dqOut,
  output reg dqOe,
  output reg chipSelectN,
  output reg writeStrobeN,
  output reg outputEnableN
);
  localparam S_IDLE = 2'd0;
  localparam S_STROBE = 2'd1;
  localparam S_GAP = 2'd2;
  reg [1:0] state_q;
  reg [3:0] cnt_q;
  reg wr_q;
  reg [7:0] dqSync1_q;
  reg [7:0] dqSync2_q;
  // Busy covers the done cycle too, so a caller cannot restart before it has seen done
  assign busy = (state_q != S_IDLE) | done;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dqSync1_q <= 8'h00;
      dqSync2_q <= 8'h00;
    end else begin
      dqSync1_q <= dqIn;
      dqSync2_q <= dqSync1_q;
    end
  end
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      flashAddr <= 20'h00000;
      dqOut <= 8'h00;
      dqOe <= 1'b0;
      chipSelectN <= 1'b1;
      writeStrobeN <= 1'b1;
      outputEnableN <= 1'b1;
    end else begin
      done <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start) begin
            state_q <= S_STROBE;
            cnt_q <= `FCSU_STROBE_CYCLES;
            wr_q <= isWrite;
            flashAddr <= addr;
            dqOut <= wdata;
            dqOe <= isWrite;
            chipSelectN <= 1'b0;
            writeStrobeN <= ~isWrite;
            outputEnableN <= isWrite;
          end
        end
        S_STROBE: begin
          if (cnt_q == 4'h0) begin
            // Rising strobe latches address and data; read data sampled before release.
            // Select stays low one more cycle so the rising write strobe still sees it.
            writeStrobeN <= 1'b1;
            outputEnableN <= 1'b1;
            if (!wr_q) begin
              rdata <= dqSync2_q;
            end
            state_q <= S_GAP;
            cnt_q <= `FCSU_GAP_CYCLES;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_GAP: begin
          dqOe <= 1'b0;
          chipSelectN <= 1'b1;
          if (cnt_q == 4'h0) begin
            state_q <= S_IDLE;
            done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // fcsu_bus_cycle
`default_nettype wire

// ### tb/fcsu_host_sva.sv
// Checker on the flash pins of the host controller
`timescale 1ns/1ps
`default_nettype none
module fcsu_host_sva (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] dqOut,
  input wire logic dqOe,
  input wire logic [19:0] flashAddr,
  input wire logic chipSelectN,
  input wire logic writeStrobeN,
  input wire logic outputEnableN,
  input wire logic powerdown_reset_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence selHeld;
    !chipSelectN [*4];
  endsequence
  sequence selFree;
    ##[0:2] chipSelectN;
  endsequence
  chk_strobe_under_sel: assert property (chipSelectN |-> writeStrobeN && outputEnableN)
    else $error("strobe outside select");
  chk_no_overlap: assert property (!outputEnableN |-> writeStrobeN)
    else $error("read and write strobes together");
  chk_write_drives: assert property (!writeStrobeN |-> dqOe)
    else $error("write without data drive");
  chk_read_released: assert property (!outputEnableN |-> !dqOe)
    else $error("data driven during read");
  chk_sel_toggle: assert property ($fell(outputEnableN) |-> $fell(chipSelectN))
    else $error("read without fresh select");
  chk_cycle_len: assert property ($fell(chipSelectN) |-> selHeld ##1 selFree)
    else $error("select length wrong");
  chk_write_hold: assert property ($past(!writeStrobeN) |-> $stable(flashAddr) && $stable(dqOut))
    else $error("address or data moved in write");
  chk_pd_quiet: assert property (!powerdown_reset_n |-> chipSelectN)
    else $error("access in powerdown");
endmodule // fcsu_host_sva
bind fcsu_host fcsu_host_sva chk (.mclk, .rstn, .dqOut, .dqOe, .flashAddr, .chipSelectN,
  .writeStrobeN, .outputEnableN, .powerdown_reset_n);
`default_nettype wire

// ### tb/fcsu_flash_model.sv
// Behavioural byte-wide flash device on the far side of the host
`timescale 1ns/1ps
`default_nettype none
module fcsu_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEV_CODE = 8'hC3, // Arbitrary value
  parameter int BUSY_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic rpN,
  input wire logic supplyHigh,
  input wire logic failOp,
  input wire logic [19:0] addr,
  input wire logic [7:0] dqIn,
  output logic [7:0] dqOut,
  output logic readyBusyN
);
  logic [7:0] mem [0:255];
  logic [7:0] latchSr, wAddr, wData, v;
  logic [3:0] sr;
  logic [1:0] mode, pend, job;
  int cnt;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  end
  always @(posedge weN or negedge rpN) begin
    if (!rpN) begin
      mode = 2'h0;
      sr = 4'h0;
      pend = 2'h0;
      job = 2'h0;
    end else if (!ceN) begin
      if (job != 2'h0) begin
        if (dqIn == 8'h70 || (job == 2'h1 && dqIn == 8'hB0)) mode = 2'h2;
        if (job == 2'h1) sr[3] = (dqIn == 8'hB0) || (sr[3] && dqIn != 8'hD0);
      end else if (pend != 2'h0) begin
        mode = 2'h2;
        if (pend == 2'h1 && dqIn != 8'hD0) sr[2:1] = 2'h3;
        else if (!supplyHigh) sr[0] = 1'h1;
        else begin
          job = pend;
          wAddr = addr[7:0];
          wData = dqIn;
          cnt = BUSY_CYCLES;
        end
        pend = 2'h0;
      end else case (dqIn)
        8'hFF: mode = 2'h0;
        8'h90: mode = 2'h1;
        8'h70: mode = 2'h2;
        8'h50: sr = 4'h0;
        8'h20: pend = 2'h1;
        8'h40, 8'h10: pend = 2'h2;
        default: ;
      endcase
    end
  end
  // Errors accumulate; only the clear command or a low powerdown input resets them
  always @(posedge mclk) begin
    if (job != 2'h0 && !sr[3] && --cnt == 0) begin
      if (failOp) sr[3 - job] = 1'h1;
      else if (job == 2'h1) for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
      else mem[wAddr] = wData;
      job = 2'h0;
    end
  end
  // Reserved bits read non-zero so that a host which forgets to mask them is caught
  always @(negedge oeN or negedge ceN) begin
    if (!oeN && !ceN) latchSr = {(job == 2'h0 || sr[3]), sr, 3'h5};
  end
  always @* begin
    v = mode == 2'h2 ? latchSr : mode == 2'h1 ? (addr[0] ? DEV_CODE : MFR_CODE) : mem[addr[7:0]];
    dqOut = (!ceN && !oeN && rpN) ? v : ~v;
  end
  assign readyBusyN = job == 2'h0 || sr[3];
endmodule // fcsu_flash_model
`default_nettype wire

// ### tb/flash_command_status_unit_tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
`include "fcsu_consts.vh"
module flash_command_status_unit_tb_top;
  typedef struct {logic [2:0] opc; logic [7:0] cmd, a, exp;} fcsu_row_t;
  localparam logic [7:0] MFR = 8'h3C;
  localparam logic [7:0] DEV = 8'hC3;
  fcsu_row_t rows [13] = '{'{1, 8'hFF, 0, 0}, '{2, 0, 5, 8'h05}, '{1, 8'h90, 0, 0},
    '{2, 0, 0, MFR}, '{2, 0, 1, DEV}, '{1, 8'h70, 0, 0}, '{2, 0, 5, 8'h85}, '{3, 0, 7, 0},
    '{1, 8'hFF, 0, 0}, '{2, 0, 7, 8'h3C}, '{4, 0, 7, 0}, '{1, 8'hFF, 0, 0}, '{2, 0, 7, 8'hFF}};
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic supplyHigh = 1'h1;
  logic failOp = 1'h0;
  logic [31:0] rd;
  int err_count = 0;
  int checks = 0;
  wire [31:0] prdata;
  wire [7:0] dqIn, dqOut;
  wire [19:0] flashAddr;
  wire pready, pslverr, dqOe, chipSelectN, writeStrobeN, outputEnableN;
  wire powerdown_reset_n, ready_busy_n;
  fcsu_host dut (.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .dqIn, .dqOut, .dqOe, .flashAddr, .chipSelectN, .writeStrobeN, .outputEnableN,
    .powerdown_reset_n, .ready_busy_n);
  fcsu_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (.mclk, .ceN(chipSelectN),
    .weN(writeStrobeN), .oeN(outputEnableN), .rpN(powerdown_reset_n), .supplyHigh, .failOp,
    .addr(flashAddr), .dqIn(dqOut), .dqOut(dqIn), .readyBusyN(ready_busy_n));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n == 50) begin
      err_count++;
      tally_and_finish();
    end
    @(posedge mclk);
  endtask
  task automatic op(input logic [2:0] opc, input logic [7:0] cmd, a, d);
    int n = 0;
    apb(1'h1, `FCSU_REG_ADDR, {24'h0, a});
    apb(1'h1, `FCSU_REG_WDATA, {24'h0, d});
    apb(1'h1, `FCSU_REG_CTRL, {16'h8000, cmd, 5'h00, opc});
    do begin
      apb(1'h0, `FCSU_REG_STATUS, 32'h0);
      n++;
    end while ((rd[9] !== 1'h1 || rd[8] !== 1'h0) && n < 500);
    if (n == 500) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    chk(powerdown_reset_n, 32'h0);
    rstn <= 1'h1;
    @(posedge mclk);
    apb(1'h1, `FCSU_REG_CTRL, 32'h80000000);
    foreach (rows[i]) begin
      op(rows[i].opc, rows[i].cmd, rows[i].a, 8'h3C);
      if (rows[i].opc == `FCSU_OP_READ) begin
        apb(1'h0, `FCSU_REG_RDATA, 32'h0);
        chk(rd, {24'h0, rows[i].exp});
      end
    end
    for (int k = 0; k < 2; k++) begin
      failOp <= k == 0;
      op(`FCSU_OP_ERASE, 8'h00, 8'h07, 8'h00);
      chk(rd[7:0], 8'hA0);
    end
    failOp <= 1'h0;
    op(`FCSU_OP_CMD, 8'h50, 8'h00, 8'h00);
    op(`FCSU_OP_POLL, 8'h70, 8'h00, 8'h00);
    chk(rd[7:0], 8'h80);
    supplyHigh <= 1'h0;
    op(`FCSU_OP_PROGRAM, 8'h00, 8'h09, 8'h00);
    chk(rd[7:0], 8'h88);
    op(`FCSU_OP_PROGRAM, 8'h00, 8'h09, 8'h00);
    chk(rd[10], 32'h1);
    op(`FCSU_OP_CMD, 8'h50, 8'h00, 8'h00);
    op(`FCSU_OP_CMD, 8'hFF, 8'h00, 8'h00);
    op(`FCSU_OP_READ, 8'h00, 8'h09, 8'h00);
    apb(1'h0, `FCSU_REG_RDATA, 32'h0);
    chk(rd, 32'hFF);
    supplyHigh <= 1'h1;
    apb(1'h1, `FCSU_REG_CTRL, 32'h80003301);
    apb(1'h0, `FCSU_REG_STATUS, 32'h0);
    chk(rd[10], 32'h1);
    op(`FCSU_OP_CMD, 8'h70, 8'h00, 8'h00);
    apb(1'h1, `FCSU_REG_CTRL, 32'h0);
    chk(powerdown_reset_n, 32'h0);
    apb(1'h1, `FCSU_REG_CTRL, 32'h80000000);
    op(`FCSU_OP_READ, 8'h00, 8'h07, 8'h00);
    apb(1'h0, `FCSU_REG_RDATA, 32'h0);
    chk(rd, 32'hFF);
    apb(1'h0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule // flash_command_status_unit_tb_top
`default_nettype wire
